// ==== shared/cml_defs.svh ====
`ifndef CML_DEFS_SVH
`define CML_DEFS_SVH
`define CML_DATA_W 8
`define CML_PC_W 11
`define CML_RADDR_W 7
`define CML_SEL_W 4
`define CML_SP_W 3
`define CML_STACK_DEPTH 8
`define CML_SEL_MIN 4'h5
`define CML_SEL_MAX 4'hf
`define CML_SFR_COUNT 16
`define CML_RAM_WORDS 128
`define CML_RST_DATA 8'h00
`define CML_RST_PC 11'h000
`define CML_RST_SP 3'h0
`define CML_PC_STEP 11'h001
`define CML_SP_STEP 3'h1
`endif

// ==== shared/cml_pkg.sv ====
package cml_pkg;
  typedef enum logic [2:0] {
    CML_OP_NONE,
    CML_OP_OR_IMM,
    CML_OP_PAGE_READ,
    CML_OP_PAGE_WRITE,
    CML_OP_LONG_CALL,
    CML_OP_LONG_JUMP,
    CML_OP_LOAD_IMM,
    CML_OP_STORE_WORK
  } cml_op_type;

  typedef struct packed {
    cml_op_type op;
    logic [7:0] imm;
    logic [3:0] sel;
    logic [6:0] raddr;
    logic [10:0] target;
  } cml_instr_type;

  typedef struct packed {
    logic [7:0] work;
    logic zero;
    logic [10:0] pc;
    logic [2:0] sp;
  } cml_state_type;
endpackage

// ==== src/cml_exec.sv ====
`timescale 1ns/1ps
`include "cml_defs.svh"
module cml_exec import cml_pkg::*; (
  // Clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // Instruction issue
  input wire logic instr_valid,
  input wire cml_instr_type instr,
  output logic instr_ready,
  // Architectural state view
  output cml_state_type state,
  output logic busy,
  // Special register page
  output logic [`CML_SEL_W-1:0] sfr_addr,
  output logic [`CML_DATA_W-1:0] sfr_wdata,
  output logic sfr_we,
  // Data memory read port and call stack top
  input wire logic [`CML_RADDR_W-1:0] mem_raddr,
  output logic [`CML_DATA_W-1:0] mem_rdata,
  output logic [`CML_DATA_W-1:0] stack_top
);

  // ======================================================
  // State
  logic [`CML_DATA_W-1:0] work_r, work_nxt;
  logic zero_r, zero_nxt;
  logic [`CML_PC_W-1:0] pc_r, pc_nxt;
  logic [`CML_SP_W-1:0] sp_r, sp_nxt;
  logic [`CML_PC_W-1:0] tgt_r, tgt_nxt;
  logic [`CML_DATA_W-1:0] sfr_r [`CML_SFR_COUNT];
  logic [`CML_DATA_W-1:0] ram_r [`CML_RAM_WORDS];
  logic [`CML_PC_W-1:0] stk_r [`CML_STACK_DEPTH];
  logic [`CML_SEL_W-1:0] sfr_addr_r, sfr_addr_nxt;
  logic [`CML_DATA_W-1:0] sfr_wdata_r, sfr_wdata_nxt;
  logic sfr_we_r, sfr_we_nxt;

  typedef enum logic [1:0] {ST_IDLE, ST_CALL, ST_JUMP} cml_fsm_type;
  cml_fsm_type fsm_r, fsm_nxt;

  logic take;
  logic sel_ok;
  logic ram_we;
  logic push;
  logic [`CML_DATA_W-1:0] or_res;
  logic [`CML_DATA_W-1:0] sfr_rd;

  assign instr_ready = (fsm_r == ST_IDLE);
  assign busy = (fsm_r != ST_IDLE);
  assign take = instr_valid && instr_ready;
  assign sel_ok = (instr.sel >= `CML_SEL_MIN) && (instr.sel <= `CML_SEL_MAX);
  assign or_res = work_r | instr.imm;
  assign sfr_rd = sfr_r[instr.sel];

  // ======================================================
  // Next state
  always_comb begin
    work_nxt = work_r;
    zero_nxt = zero_r;
    pc_nxt = pc_r;
    sp_nxt = sp_r;
    tgt_nxt = tgt_r;
    fsm_nxt = fsm_r;
    sfr_addr_nxt = sfr_addr_r;
    sfr_wdata_nxt = sfr_wdata_r;
    sfr_we_nxt = 1'b0;
    ram_we = 1'b0;
    push = 1'b0;
    unique case (fsm_r)
      ST_IDLE: begin
        if (take) begin
          pc_nxt = pc_r + `CML_PC_STEP;
          unique case (instr.op)
            CML_OP_OR_IMM: begin
              work_nxt = or_res;
              zero_nxt = (or_res == `CML_RST_DATA);
            end
            CML_OP_PAGE_READ: begin
              if (sel_ok) begin
                work_nxt = sfr_r[instr.sel];
              end
            end
            CML_OP_PAGE_WRITE: begin
              if (sel_ok) begin
                sfr_we_nxt = 1'b1;
                sfr_addr_nxt = instr.sel;
                sfr_wdata_nxt = work_r;
              end
            end
            CML_OP_LONG_CALL: begin
              push = 1'b1;
              sp_nxt = sp_r + `CML_SP_STEP;
              tgt_nxt = instr.target;
              fsm_nxt = ST_CALL;
            end
            CML_OP_LONG_JUMP: begin
              tgt_nxt = instr.target;
              fsm_nxt = ST_JUMP;
            end
            CML_OP_LOAD_IMM: begin
              work_nxt = instr.imm;
            end
            CML_OP_STORE_WORK: begin
              ram_we = 1'b1;
            end
            CML_OP_NONE: begin
            end
          endcase
        end
      end
      ST_CALL: begin
        pc_nxt = tgt_r;
        fsm_nxt = ST_IDLE;
      end
      ST_JUMP: begin
        pc_nxt = tgt_r;
        fsm_nxt = ST_IDLE;
      end
      default: begin
        fsm_nxt = ST_IDLE;
      end
    endcase
  end

  // ======================================================
  // Registers
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      work_r <= `CML_RST_DATA;
      zero_r <= 1'b0;
      pc_r <= `CML_RST_PC;
      sp_r <= `CML_RST_SP;
      tgt_r <= `CML_RST_PC;
      fsm_r <= ST_IDLE;
      sfr_addr_r <= `CML_SEL_MIN;
      sfr_wdata_r <= `CML_RST_DATA;
      sfr_we_r <= 1'b0;
    end else begin
      work_r <= work_nxt;
      zero_r <= zero_nxt;
      pc_r <= pc_nxt;
      sp_r <= sp_nxt;
      tgt_r <= tgt_nxt;
      fsm_r <= fsm_nxt;
      sfr_addr_r <= sfr_addr_nxt;
      sfr_wdata_r <= sfr_wdata_nxt;
      sfr_we_r <= sfr_we_nxt;
    end
  end

  // Memories, no reset
  always_ff @(posedge clk) begin
    if (sfr_we_nxt) begin
      sfr_r[sfr_addr_nxt] <= sfr_wdata_nxt;
    end
    if (ram_we) begin
      ram_r[instr.raddr] <= work_r;
    end
    if (push) begin
      stk_r[sp_r] <= pc_r + `CML_PC_STEP;
    end
  end

  logic [`CML_DATA_W-1:0] mem_rdata_r;
  logic [`CML_DATA_W-1:0] stack_top_r;
  always_ff @(posedge clk) begin
    mem_rdata_r <= ram_r[mem_raddr];
    stack_top_r <= stk_r[sp_r - `CML_SP_STEP][`CML_DATA_W-1:0];
  end

  assign mem_rdata = mem_rdata_r;
  assign stack_top = stack_top_r;
  assign sfr_addr = sfr_addr_r;
  assign sfr_wdata = sfr_wdata_r;
  assign sfr_we = sfr_we_r;
  assign state = '{work: work_r, zero: zero_r, pc: pc_r, sp: sp_r};

  // ======================================================
  // Checks
  a_or_result: assert property (@(posedge clk) disable iff (sys_rst)
    take && instr.op == CML_OP_OR_IMM |=> work_r == ($past(work_r) | $past(instr.imm)))
    else $error("or result wrong");
  a_zero_flag: assert property (@(posedge clk) disable iff (sys_rst)
    take && instr.op == CML_OP_OR_IMM |=> zero_r == (work_r == `CML_RST_DATA))
    else $error("zero flag wrong");
  a_page_read: assert property (@(posedge clk) disable iff (sys_rst)
    take && instr.op == CML_OP_PAGE_READ && sel_ok |=> $stable(zero_r))
    else $error("page read touched flag");
  a_page_write: assert property (@(posedge clk) disable iff (sys_rst)
    take && instr.op == CML_OP_PAGE_WRITE && sel_ok |=> sfr_we && sfr_wdata == $past(work_r))
    else $error("page write missing");
  a_call_push: assert property (@(posedge clk) disable iff (sys_rst)
    take && instr.op == CML_OP_LONG_CALL |=> sp_r == $past(sp_r) + `CML_SP_STEP ##1 !busy)
    else $error("call push wrong");
  a_call_target: assert property (@(posedge clk) disable iff (sys_rst)
    take && instr.op == CML_OP_LONG_CALL |=> ##1 pc_r == $past(instr.target, 2))
    else $error("call target wrong");
  a_jump_target: assert property (@(posedge clk) disable iff (sys_rst)
    take && instr.op == CML_OP_LONG_JUMP |=> $stable(sp_r) ##1 pc_r == $past(instr.target, 2))
    else $error("jump target wrong");
  a_load_imm: assert property (@(posedge clk) disable iff (sys_rst)
    take && instr.op == CML_OP_LOAD_IMM |=> work_r == $past(instr.imm) && $stable(zero_r))
    else $error("load immediate wrong");
  a_store_flags: assert property (@(posedge clk) disable iff (sys_rst)
    take && instr.op == CML_OP_STORE_WORK |=> $stable(zero_r) && $stable(work_r))
    else $error("store changed state");
  a_page_read_data: assert property (@(posedge clk) disable iff (sys_rst)
    take && instr.op == CML_OP_PAGE_READ && sel_ok |=> work_r == $past(sfr_rd))
    else $error("page read data wrong");
  a_page_write_addr: assert property (@(posedge clk) disable iff (sys_rst)
    take && instr.op == CML_OP_PAGE_WRITE && sel_ok
    |=> sfr_addr == $past(instr.sel) && $stable(zero_r))
    else $error("page write address wrong");
  a_call_stack: assert property (@(posedge clk) disable iff (sys_rst)
    take && instr.op == CML_OP_LONG_CALL
    |=> busy && !instr_ready && stk_r[$past(sp_r)] == $past(pc_r) + `CML_PC_STEP)
    else $error("call return address wrong");
  a_jump_hold: assert property (@(posedge clk) disable iff (sys_rst)
    take && instr.op == CML_OP_LONG_JUMP
    |=> busy && $stable(zero_r) && $stable(work_r) ##1 !busy && $stable(sp_r))
    else $error("jump changed state");
  a_store_data: assert property (@(posedge clk) disable iff (sys_rst)
    take && instr.op == CML_OP_STORE_WORK |=> ram_r[$past(instr.raddr)] == $past(work_r))
    else $error("store data wrong");
endmodule

// ==== tb/test_cpu_move_logic_branch_ops.sv ====
`timescale 1ns/1ps
`include "cml_defs.svh"
module test_cpu_move_logic_branch_ops import cml_pkg::*;;
  logic clk = 0;
  logic sys_rst = 1;
  logic instr_valid = 0;
  cml_instr_type instr = '0;
  logic [6:0] mem_raddr = '0;
  logic instr_ready, busy, sfr_we;
  cml_state_type state;
  logic [3:0] sfr_addr;
  logic [7:0] sfr_wdata, mem_rdata, stack_top;
  int err_count = 0;
  int tests_run = 0;
  int cyc = 0;
  logic [31:0] seed = 32'ha14413a6;
  logic [7:0] m_work = '0;
  logic [7:0] sfr_q [16];
  logic [7:0] ram_q [128];
  logic m_zero = 0;
  logic [10:0] m_pc = '0;
  logic [2:0] m_sp = '0;
  always #50 clk = ~clk;
  cml_exec i_dut (.clk(clk), .sys_rst(sys_rst), .instr_valid(instr_valid), .instr(instr),
    .instr_ready(instr_ready), .state(state), .busy(busy), .sfr_addr(sfr_addr),
    .sfr_wdata(sfr_wdata), .sfr_we(sfr_we), .mem_raddr(mem_raddr), .mem_rdata(mem_rdata),
    .stack_top(stack_top));
  // ==========================================
  // Helpers
  function automatic logic [31:0] rnd();
    seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
    return seed;
  endfunction
  task automatic chk_val(input string n, input logic [10:0] e, input logic [10:0] g);
    tests_run++;
    if (g !== e) begin
      err_count++;
      $display("unexpected %s: expected %h, seen %h", n, e, g);
    end
  endtask
  task automatic chk_state();
    cml_state_type e;
    e = {m_work, m_zero, m_pc, m_sp};
    tests_run++;
    if (state !== e) begin
      err_count++;
      $display("unexpected state: expected %h, seen %h", e, state);
    end
  endtask
  task automatic end_of_test();
    $display("checks %0d, mismatches %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  // Offer one op, run the model, compare
  task automatic exec(input cml_op_type op, input logic [31:0] r);
    logic [7:0] ret;
    instr = '{op: op, imm: r[7:0], sel: r[11:8], raddr: r[18:12], target: r[29:19]};
    instr_valid = 1;
    @(posedge clk);
    #1;
    m_pc = m_pc + 11'h001;
    case (op)
      CML_OP_OR_IMM: begin
        m_work = m_work | r[7:0];
        m_zero = (m_work == 8'h00);
      end
      CML_OP_PAGE_READ: if (r[11:8] >= 4'h5) m_work = sfr_q[r[11:8]];
      CML_OP_PAGE_WRITE: begin
        chk_val("sfr_we", {10'h0, r[11:8] >= 4'h5}, {10'h0, sfr_we});
        if (r[11:8] >= 4'h5) begin
          sfr_q[r[11:8]] = m_work;
          chk_val("sfr_addr", {7'h0, r[11:8]}, {7'h0, sfr_addr});
          chk_val("sfr_wdata", {3'h0, m_work}, {3'h0, sfr_wdata});
        end
      end
      CML_OP_LOAD_IMM: m_work = r[7:0];
      CML_OP_STORE_WORK: ram_q[r[18:12]] = m_work;
      CML_OP_LONG_CALL: m_sp = m_sp + 3'h1;
      default: ;
    endcase
    chk_state();
    if (op == CML_OP_LONG_CALL || op == CML_OP_LONG_JUMP) begin
      instr_valid = 0;
      ret = m_pc[7:0];
      chk_val("busy", 11'h1, {10'h0, busy});
      chk_val("ready", 11'h0, {10'h0, instr_ready});
      @(posedge clk);
      #1;
      m_pc = r[29:19];
      chk_state();
      if (op == CML_OP_LONG_CALL) chk_val("stack_top", {3'h0, ret}, {3'h0, stack_top});
    end
  endtask
  // ==========================================
  // Timeout
  always @(posedge clk) begin
    cyc++;
    if (cyc >= 20000) begin
      err_count++;
      end_of_test();
    end
  end
  // ==========================================
  // Main sequence
  initial begin
    logic [31:0] r;
    repeat (10) @(posedge clk);
    #1;
    sys_rst = 0;
    chk_state();
    chk_val("ready", 11'h1, {10'h0, instr_ready});
    $display("test reset done");
    exec(CML_OP_LOAD_IMM, 32'h0);
    exec(CML_OP_OR_IMM, 32'h0);
    exec(CML_OP_LOAD_IMM, 32'h5);
    exec(CML_OP_OR_IMM, 32'ha0);
    $display("test zero flag done");
    for (int s = 3; s < 16; s++) begin
      exec(CML_OP_LOAD_IMM, rnd());
      r = rnd();
      r[11:8] = s[3:0];
      exec(CML_OP_PAGE_WRITE, r);
    end
    $display("test page write done");
    repeat (2000) begin
      r = rnd();
      exec(cml_op_type'(r[31:29]), r);
    end
    instr_valid = 0;
    $display("test random ops done");
    sys_rst = 1;
    repeat (2) @(posedge clk);
    #1;
    sys_rst = 0;
    m_work = '0;
    m_zero = 0;
    m_pc = '0;
    m_sp = '0;
    chk_state();
    chk_val("ready", 11'h1, {10'h0, instr_ready});
    chk_val("sfr_we", 11'h0, {10'h0, sfr_we});
    exec(CML_OP_LOAD_IMM, 32'h3c);
    instr_valid = 0;
    $display("test mid reset done");
    for (int a = 0; a < 128; a++) begin
      mem_raddr = a[6:0];
      @(posedge clk);
      #1;
      if (!$isunknown(ram_q[a])) chk_val("mem_rdata", {3'h0, ram_q[a]}, {3'h0, mem_rdata});
    end
    $display("test memory readback done");
    end_of_test();
  end
endmodule
